/* File: rtl/dtc_pkg.sv */
package dtc_pkg;

    // core clock and machine cycle
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned MC_CLKS      = 12;
    localparam logic [3:0]  MC_LAST      = 4'(MC_CLKS - 1);
    // phase index: state n, phase p -> (n-1)*2 + (p-1)
    localparam logic [3:0]  UPDATE_PHASE = 4'h4;
    localparam logic [3:0]  SAMPLE_PHASE = 4'h9;

    // register offsets
    localparam logic [3:0]  OFF_MODE     = 4'h0;
    localparam logic [3:0]  OFF_CTRL     = 4'h1;
    localparam logic [3:0]  OFF_C0_LOW   = 4'h2;
    localparam logic [3:0]  OFF_C0_HIGH  = 4'h3;
    localparam logic [3:0]  OFF_C1_LOW   = 4'h4;
    localparam logic [3:0]  OFF_C1_HIGH  = 4'h5;
    localparam logic [3:0]  OFF_IRQ_STAT = 4'h6;
    localparam logic [3:0]  OFF_IRQ_EN   = 4'h7;
    localparam logic [3:0]  OFF_IRQ_CLR  = 4'h8;

    // mode register fields, counter one sits one nibble up
    localparam int unsigned MD_SEL_LOW   = 0;
    localparam int unsigned MD_SEL_HIGH  = 1;
    localparam int unsigned MD_COUNT_SEL = 2;
    localparam int unsigned MD_GATE      = 3;
    localparam int unsigned MD_C1_BASE   = 4;

    // control register fields
    localparam int unsigned CTL_TYPE0    = 0;
    localparam int unsigned CTL_EDGE0    = 1;
    localparam int unsigned CTL_TYPE1    = 2;
    localparam int unsigned CTL_EDGE1    = 3;
    localparam int unsigned CTL_RUN0     = 4;
    localparam int unsigned CTL_OVF0     = 5;
    localparam int unsigned CTL_RUN1     = 6;
    localparam int unsigned CTL_OVF1     = 7;

    // interrupt event bits
    localparam int unsigned EV_OVF0      = 0;
    localparam int unsigned EV_OVF1      = 1;
    localparam int unsigned EV_EXT0      = 2;
    localparam int unsigned EV_EXT1      = 3;
    localparam int unsigned EV_N         = 4;

    // reset values
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  RST_EV       = 4'h0;

    typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_SPLIT} dtc_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dtc_bus_t;

endpackage : dtc_pkg

/* File: rtl/dtc_core.sv */
module dtc_core
    import dtc_pkg::*;
(
    // clock and reset
    input  wire logic     clk,
    input  wire logic     rst_b,
    // register port
    input  wire dtc_bus_t bus,
    output logic [7:0]    rd_data_q,
    // count and gate pins
    input  wire logic     count_pin_zero,
    input  wire logic     count_pin_one,
    input  wire logic     gate_pin_zero,
    input  wire logic     gate_pin_one,
    // events out
    output logic          irq_q,
    output logic          baud_tick_q
);

    // next count for modes 0 to 2; mode 3 holds
    function automatic logic [16:0] dtc_step(input dtc_mode_t md, input logic [15:0] cnt);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        c13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
        c16 = {1'b0, cnt} + 17'h00001;
        c8  = {1'b0, cnt[7:0]} + 9'h001;
        unique case (md)
            DTC_M13:   dtc_step = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
            DTC_M16:   dtc_step = c16;
            DTC_M8R:   dtc_step = c8[8] ? {1'b1, cnt[15:8], cnt[15:8]} : {1'b0, cnt[15:8], c8[7:0]};
            DTC_SPLIT: dtc_step = {1'b0, cnt};
        endcase
    endfunction : dtc_step

    // register write decode
    function automatic logic wr_hit(input dtc_bus_t b, input logic [3:0] off);
        wr_hit = b.wr && (b.addr == off);
    endfunction : wr_hit

    logic [3:0]  phase_q;
    logic [3:0]  meta_q;
    logic [3:0]  sync_q;
    logic [3:0]  smp_q;
    logic [3:0]  prev_q;
    logic [7:0]  mode_q;
    logic [7:0]  ctl_q;
    logic [7:0]  lo0_q;
    logic [7:0]  hi0_q;
    logic [7:0]  lo1_q;
    logic [7:0]  hi1_q;
    logic [EV_N-1:0] ist_q;
    logic [EV_N-1:0] ien_q;
    logic [7:0]  rd_mux;

    // machine cycle phase and its strobes
    wire         last     = (phase_q == MC_LAST);
    wire [3:0]   phase_d  = last ? 4'h0 : 4'(phase_q + 4'h1);
    wire         upd      = (phase_q == UPDATE_PHASE);
    wire         smp      = (phase_q == SAMPLE_PHASE);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            phase_q <= 4'h0;
        else
            phase_q <= phase_d;
    end

    // pin synchronisers and once-per-cycle samples
    wire [3:0]   pin_raw  = {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
            smp_q  <= 4'h0;
            prev_q <= 4'h0;
        end
        else
        begin
            meta_q <= pin_raw;
            sync_q <= meta_q;
            if (smp)
            begin
                smp_q  <= sync_q;
                prev_q <= smp_q;
            end
        end
    end

    // falling edge stays valid from one sample to the next
    wire [1:0]   fall     = prev_q[1:0] & ~smp_q[1:0];

    // mode fields
    wire dtc_mode_t md0   = dtc_mode_t'(mode_q[MD_SEL_HIGH:MD_SEL_LOW]);
    wire dtc_mode_t md1   = dtc_mode_t'(mode_q[MD_C1_BASE+MD_SEL_HIGH:MD_C1_BASE+MD_SEL_LOW]);
    wire         ct0      = mode_q[MD_COUNT_SEL];
    wire         ct1      = mode_q[MD_C1_BASE+MD_COUNT_SEL];
    wire         gate0    = mode_q[MD_GATE];
    wire         gate1    = mode_q[MD_C1_BASE+MD_GATE];
    wire         run0     = ctl_q[CTL_RUN0];
    wire         run1     = ctl_q[CTL_RUN1];
    wire         split    = (md0 == DTC_SPLIT);

    // increment enables, taken only at the update phase
    wire         allow0   = run0 & (~gate0 | smp_q[2]);
    wire         allow1   = ~gate1 | smp_q[3];
    wire         go1      = split ? 1'b1 : run1;
    wire         inc0     = upd & allow0 & (ct0 ? fall[0] : 1'b1);
    wire         inc0h    = upd & split & run1;
    wire         inc1     = upd & go1 & allow1 & (ct1 ? fall[1] : 1'b1) & (md1 != DTC_SPLIT);

    // counter zero next values
    wire [15:0]  cnt0_w   = {hi0_q, lo0_q};
    wire [15:0]  cnt1_w   = {hi1_q, lo1_q};
    wire [16:0]  st0      = dtc_step(md0, cnt0_w);
    wire [8:0]   lo0s     = {1'b0, lo0_q} + 9'h001;
    wire [8:0]   hi0s     = {1'b0, hi0_q} + 9'h001;
    wire [7:0]   lo0_n    = ~inc0 ? lo0_q : (split ? lo0s[7:0] : st0[7:0]);
    wire [7:0]   hi0_n    = split ? (inc0h ? hi0s[7:0] : hi0_q) : (inc0 ? st0[15:8] : hi0_q);
    wire         ovf0_set = inc0 & (split ? lo0s[8] : st0[16]);
    wire         ovfh_set = inc0h & hi0s[8];

    // counter one next values
    wire [16:0]  st1      = dtc_step(md1, cnt1_w);
    wire [7:0]   lo1_n    = inc1 ? st1[7:0] : lo1_q;
    wire [7:0]   hi1_n    = inc1 ? st1[15:8] : hi1_q;
    wire         ovf1_cnt = inc1 & st1[16];
    wire         ovf1_set = split ? ovfh_set : ovf1_cnt;

    // gate pin request flags, edge or low level per type bit
    wire         ext0_set = smp & (ctl_q[CTL_TYPE0] ? (smp_q[2] & ~sync_q[2]) : ~sync_q[2]);
    wire         ext1_set = smp & (ctl_q[CTL_TYPE1] ? (smp_q[3] & ~sync_q[3]) : ~sync_q[3]);

    // register write decode
    wire         wr_mode  = wr_hit(bus, OFF_MODE);
    wire         wr_ctl   = wr_hit(bus, OFF_CTRL);
    wire         wr_lo0   = wr_hit(bus, OFF_C0_LOW);
    wire         wr_hi0   = wr_hit(bus, OFF_C0_HIGH);
    wire         wr_lo1   = wr_hit(bus, OFF_C1_LOW);
    wire         wr_hi1   = wr_hit(bus, OFF_C1_HIGH);
    wire         wr_ien   = wr_hit(bus, OFF_IRQ_EN);
    wire         wr_clr   = wr_hit(bus, OFF_IRQ_CLR);

    // control register: hardware sets win over software writes
    wire [7:0]   ctl_w    = wr_ctl ? bus.wdata : ctl_q;
    wire [7:0]   ctl_set  = (8'(ovf1_set) << CTL_OVF1) | (8'(ovf0_set) << CTL_OVF0)
                          | (8'(ext1_set) << CTL_EDGE1) | (8'(ext0_set) << CTL_EDGE0);
    wire [7:0]   ctl_d    = ctl_w | ctl_set;

    // interrupt status, enable and clear
    wire [EV_N-1:0] ev    = {ext1_set, ext0_set, ovf1_set, ovf0_set};
    wire [EV_N-1:0] clr_w = wr_clr ? bus.wdata[EV_N-1:0] : RST_EV;
    wire [EV_N-1:0] ist_d = (ist_q & ~clr_w) | ev;
    wire [EV_N-1:0] ien_d = wr_ien ? bus.wdata[EV_N-1:0] : ien_q;

    // state registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            mode_q <= RST_BYTE;
            ctl_q  <= RST_BYTE;
            ist_q  <= RST_EV;
            ien_q  <= RST_EV;
        end
        else
        begin
            mode_q <= wr_mode ? bus.wdata : mode_q;
            ctl_q  <= ctl_d;
            ist_q  <= ist_d;
            ien_q  <= ien_d;
        end
    end

    // count registers, a software write overrides the count step
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            lo0_q <= RST_BYTE;
            hi0_q <= RST_BYTE;
            lo1_q <= RST_BYTE;
            hi1_q <= RST_BYTE;
        end
        else
        begin
            lo0_q <= wr_lo0 ? bus.wdata : lo0_n;
            hi0_q <= wr_hi0 ? bus.wdata : hi0_n;
            lo1_q <= wr_lo1 ? bus.wdata : lo1_n;
            hi1_q <= wr_hi1 ? bus.wdata : hi1_n;
        end
    end

    // read selection, unmapped and write-only read zero
    always_comb
    begin
        unique case (bus.addr)
            OFF_MODE:     rd_mux = mode_q;
            OFF_CTRL:     rd_mux = ctl_q;
            OFF_C0_LOW:   rd_mux = lo0_q;
            OFF_C0_HIGH:  rd_mux = hi0_q;
            OFF_C1_LOW:   rd_mux = lo1_q;
            OFF_C1_HIGH:  rd_mux = hi1_q;
            OFF_IRQ_STAT: rd_mux = {4'h0, ist_q};
            OFF_IRQ_EN:   rd_mux = {4'h0, ien_q};
            default:      rd_mux = 8'h00;
        endcase
    end

    // outputs
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rd_data_q   <= 8'h00;
            irq_q       <= 1'b0;
            baud_tick_q <= 1'b0;
        end
        else
        begin
            rd_data_q   <= bus.rd ? rd_mux : 8'h00;
            irq_q       <= |(ist_d & ien_d);
            baud_tick_q <= ovf1_cnt;
        end
    end

    // checks
    a_phase_wrap: assert property (@(posedge clk) disable iff (!rst_b)
        last |=> (phase_q == 4'h0) ##11 (phase_q == MC_LAST))
        else $error("machine cycle is not twelve clocks");

    a_timer_full: assert property (@(posedge clk) disable iff (!rst_b)
        (upd && md0 == DTC_M16 && !ct0 && run0 && !gate0 && !bus.wr)
        |=> (cnt0_w == 16'($past(cnt0_w) + 16'h0001)))
        else $error("timer did not step by one");

    a_update_phase: assert property (@(posedge clk) disable iff (!rst_b)
        (!upd && !bus.wr) |=> ($stable(cnt0_w) && $stable(cnt1_w)))
        else $error("count changed outside update phase");

    a_pin_edge: assert property (@(posedge clk) disable iff (!rst_b)
        (upd && ct0 && !fall[0] && !split && !bus.wr) |=> $stable(cnt0_w))
        else $error("pin counter moved without edge");

    a_gate_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (gate0 && !smp_q[2] && !split && !bus.wr) |=> $stable(cnt0_w))
        else $error("gated counter moved");

    a_mode0_carry: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && md0 == DTC_M13 && lo0_q[4:0] == 5'h1F && !bus.wr)
        |=> (hi0_q == 8'($past(hi0_q) + 8'h01)) && (lo0_q[7:5] == $past(lo0_q[7:5])))
        else $error("mode 0 carry wrong");

    a_reload: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && md0 == DTC_M8R && lo0_q == 8'hFF && !bus.wr)
        |=> (lo0_q == hi0_q) && ctl_q[CTL_OVF0])
        else $error("reload or flag missing");

    a_freeze_one: assert property (@(posedge clk) disable iff (!rst_b)
        (md1 == DTC_SPLIT && !bus.wr) |=> $stable(cnt1_w))
        else $error("counter one moved in mode 3");

    a_split_high: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0h && hi0_q == 8'hFF && !bus.wr) |=> (hi0_q == 8'h00) && ctl_q[CTL_OVF1])
        else $error("split high byte overflow wrong");

    a_flag_wins: assert property (@(posedge clk) disable iff (!rst_b)
        ovf0_set |=> ctl_q[CTL_OVF0] && ist_q[EV_OVF0])
        else $error("overflow flag lost");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (irq_q == |(ist_q & ien_q)))
        else $error("interrupt output mismatch");

    // checks on sampling, gating, split mode and the register port
    a_phase_range: assert property (@(posedge clk) disable iff (!rst_b)
        phase_q <= MC_LAST)
        else $error("machine cycle phase out of range");

    a_sample_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !smp |=> ($stable(smp_q) && $stable(prev_q)))
        else $error("pin sample moved off the sample phase");

    a_sample_take: assert property (@(posedge clk) disable iff (!rst_b)
        smp |=> (smp_q == $past(sync_q)) && (prev_q == $past(smp_q)))
        else $error("pin sample not taken at the sample phase");

    a_pin_count: assert property (@(posedge clk) disable iff (!rst_b)
        (upd && ct0 && fall[0] && allow0 && md0 == DTC_M16 && !bus.wr)
        |=> (cnt0_w == 16'($past(cnt0_w) + 16'h0001)))
        else $error("recognised pin edge not counted");

    a_run_stop: assert property (@(posedge clk) disable iff (!rst_b)
        (!run0 && !split && !bus.wr) |=> $stable(cnt0_w))
        else $error("stopped counter zero moved");

    a_gate_one: assert property (@(posedge clk) disable iff (!rst_b)
        (gate1 && !smp_q[3] && !bus.wr) |=> $stable(cnt1_w))
        else $error("gated counter one moved");

    a_mode0_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && md0 == DTC_M13 && lo0_q[4:0] != 5'h1F && !bus.wr)
        |=> $stable(hi0_q) && $stable(lo0_q[7:5]))
        else $error("mode 0 touched high byte or top low bits");

    a_mode1_carry: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && md0 == DTC_M16 && lo0_q == 8'hFF && !bus.wr)
        |=> (lo0_q == 8'h00) && (hi0_q == 8'($past(hi0_q) + 8'h01)))
        else $error("mode 1 carry wrong");

    a_reload_keep: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && md0 == DTC_M8R && !bus.wr) |=> $stable(hi0_q))
        else $error("reload value changed");

    a_split_low: assert property (@(posedge clk) disable iff (!rst_b)
        (inc0 && split && !bus.wr) |=> (lo0_q == 8'($past(lo0_q) + 8'h01)))
        else $error("split low byte did not step");

    a_split_runs: assert property (@(posedge clk) disable iff (!rst_b)
        (upd && split && md1 == DTC_M16 && !ct1 && !gate1 && !bus.wr)
        |=> (cnt1_w == 16'($past(cnt1_w) + 16'h0001)))
        else $error("counter one not running while split");

    a_split_flag: assert property (@(posedge clk) disable iff (!rst_b)
        (split && !ovfh_set && !wr_ctl && !ctl_q[CTL_OVF1])
        |=> !ctl_q[CTL_OVF1])
        else $error("counter one set overflow flag one while split");

    a_baud_reload: assert property (@(posedge clk) disable iff (!rst_b)
        (inc1 && md1 == DTC_M8R && lo1_q == 8'hFF && !bus.wr)
        |=> baud_tick_q && (lo1_q == hi1_q))
        else $error("counter one overflow pulse or reload missing");

    a_status_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        !wr_clr |=> ((ist_q & $past(ist_q)) == $past(ist_q)))
        else $error("status bit lost without clear");

    a_read_idle: assert property (@(posedge clk) disable iff (!rst_b)
        !bus.rd |=> (rd_data_q == 8'h00))
        else $error("read data outside read cycle");

    a_read_ctrl: assert property (@(posedge clk) disable iff (!rst_b)
        (bus.rd && bus.addr == OFF_CTRL)
        |=> (rd_data_q == $past(ctl_q)))
        else $error("control register read wrong");

    a_ctrl_sticky: assert property (@(posedge clk) disable iff (!rst_b)
        (ctl_q[CTL_OVF0] && !wr_ctl) |=> ctl_q[CTL_OVF0])
        else $error("overflow flag zero dropped");

    a_ext_level: assert property (@(posedge clk) disable iff (!rst_b)
        (smp && !ctl_q[CTL_TYPE0] && !sync_q[2]) |=> ctl_q[CTL_EDGE0])
        else $error("low level request flag not set");

endmodule : dtc_core

/* File: bench/dtc_pin_model.sv */
// count and gate sources that sit outside the block
module dtc_pin_model (
    // clock
    input  wire logic clk,
    // pins toward the block
    output logic      count_pin_zero,
    output logic      count_pin_one,
    output logic      gate_pin_zero,
    output logic      gate_pin_one
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] cnt_q;
    logic [1:0] gate_q;

    // pins rest high between pulses
    initial
    begin
        cnt_q = 2'h3;
        gate_q = 2'h3;
    end

    // pin fan-out
    assign count_pin_zero = cnt_q[0];
    assign count_pin_one  = cnt_q[1];
    assign gate_pin_zero  = gate_q[0];
    assign gate_pin_one   = gate_q[1];

    // n falling edges, each level held two machine cycles
    task automatic pulse(input logic sel, input int n);
        repeat (n)
        begin
            @(posedge clk);
            cnt_q[sel] <= 1'b0;
            repeat (24) @(posedge clk);
            cnt_q[sel] <= 1'b1;
            repeat (24) @(posedge clk);
        end
    endtask : pulse

    // gate level change after a clock edge
    task automatic set_gate(input logic sel, input logic v);
        @(posedge clk);
        gate_q[sel] <= v;
    endtask : set_gate

endmodule : dtc_pin_model

/* File: bench/tb_top.sv */
// self-checking bench for the dual timer
module tb_top import dtc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk;
    logic       rst_b;
    dtc_bus_t   bus;
    logic [7:0] rd_data_q;
    logic       irq_q;
    logic       baud_tick_q;
    logic       cp0;
    logic       cp1;
    logic       gp0;
    logic       gp1;
    int         miscompares;
    int         check_count;
    int         baud_n;

    // clock and time-zero values
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        bus = '0;
    end
    always #5 clk = ~clk;

    // block and pin sources
    dtc_core u_dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rd_data_q(rd_data_q), .count_pin_zero(cp0),
        .count_pin_one(cp1), .gate_pin_zero(gp0), .gate_pin_one(gp1), .irq_q(irq_q), .baud_tick_q(baud_tick_q));
    dtc_pin_model u_pins (.clk(clk), .count_pin_zero(cp0), .count_pin_one(cp1), .gate_pin_zero(gp0),
        .gate_pin_one(gp1));

    // counts one-cycle overflow pulses of counter one
    always @(posedge clk)
        if (baud_tick_q)
            baud_n <= baud_n + 1;

    // one-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    // byte compare
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // read, data taken in the following cycle
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk($sformatf("reg %0d", a), e, rd_data_q);
    endtask : rchk

    // register holds 'on' for exactly k machine cycles
    task automatic win(input logic [3:0] a, input logic [7:0] on, input logic [7:0] off, input int k);
        wr(a, on);
        repeat (12 * k - 2) @(posedge clk);
        wr(a, off);
    endtask : win

    // preset both bytes of a counter
    task automatic load(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
        wr(a, lo);
        wr(a + 4'h1, hi);
    endtask : load

    // offsets 0 to 9 read zero after reset, unmapped offset 9 included
    task automatic t_reset();
        for (int a = 0; a < 10; a++)
            rchk(4'(a), RST_BYTE);
        $display("test reset done");
    endtask : t_reset

    // 16-bit timer, overflow, interrupt mask and clear
    task automatic t_timer();
        wr(OFF_MODE, 8'h01);
        load(OFF_C0_LOW, 8'h00, 8'h00);
        win(OFF_CTRL, 8'h10, 8'h00, 5);
        rchk(OFF_C0_LOW, 8'h05);
        load(OFF_C0_LOW, 8'hFF, 8'hFF);
        win(OFF_CTRL, 8'h10, 8'h00, 1);
        rchk(OFF_C0_HIGH, 8'h00);
        rchk(OFF_IRQ_STAT, 8'h01);
        chk("irq masked", 8'h00, {7'h0, irq_q});
        wr(OFF_IRQ_EN, 8'h01);
        rchk(OFF_IRQ_STAT, 8'h01);
        chk("irq on", 8'h01, {7'h0, irq_q});
        wr(OFF_IRQ_CLR, 8'h0F);
        rchk(OFF_IRQ_STAT, 8'h00);
        chk("irq off", 8'h00, {7'h0, irq_q});
        $display("test timer done");
    endtask : t_timer

    // 13-bit and auto-reload modes
    task automatic t_modes();
        wr(OFF_MODE, 8'h00);
        load(OFF_C0_LOW, 8'hFF, 8'hFF);
        win(OFF_CTRL, 8'h10, 8'h00, 1);
        rchk(OFF_C0_LOW, 8'hE0);
        rchk(OFF_C0_HIGH, 8'h00);
        rchk(OFF_IRQ_STAT, 8'h01);
        wr(OFF_IRQ_CLR, 8'h0F);
        wr(OFF_MODE, 8'h02);
        load(OFF_C0_LOW, 8'hFF, 8'hA5);
        win(OFF_CTRL, 8'h10, 8'h00, 2);
        rchk(OFF_C0_LOW, 8'hA6);
        rchk(OFF_C0_HIGH, 8'hA5);
        rchk(OFF_IRQ_STAT, 8'h01);
        wr(OFF_IRQ_CLR, 8'h0F);
        $display("test modes done");
    endtask : t_modes

    // pin counting, each counter on its own pin
    task automatic t_pins();
        wr(OFF_MODE, 8'h55);
        load(OFF_C0_LOW, 8'h00, 8'h00);
        load(OFF_C1_LOW, 8'h00, 8'h00);
        wr(OFF_CTRL, 8'h50);
        u_pins.pulse(1'b0, 3);
        u_pins.pulse(1'b1, 2);
        repeat (36) @(posedge clk);
        wr(OFF_CTRL, 8'h00);
        rchk(OFF_C0_LOW, 8'h03);
        rchk(OFF_C1_LOW, 8'h02);
        $display("test pins done");
    endtask : t_pins

    // gate pin holds the count, then lets it run
    task automatic t_gate();
        wr(OFF_MODE, 8'h09);
        load(OFF_C0_LOW, 8'h00, 8'h00);
        u_pins.set_gate(1'b0, 1'b0);
        repeat (24) @(posedge clk);
        wr(OFF_CTRL, 8'h10);
        repeat (36) @(posedge clk);
        rchk(OFF_CTRL, 8'h12);
        rchk(OFF_C0_LOW, 8'h00);
        wr(OFF_CTRL, 8'h00);
        u_pins.set_gate(1'b0, 1'b1);
        repeat (12) @(posedge clk);
        win(OFF_CTRL, 8'h10, 8'h00, 3);
        rchk(OFF_C0_LOW, 8'h03);
        $display("test gate done");
    endtask : t_gate

    // split counter zero, counter one frozen and switched by its mode
    task automatic t_split();
        int n0;
        wr(OFF_MODE, 8'h33);
        load(OFF_C0_LOW, 8'h00, 8'h00);
        load(OFF_C1_LOW, 8'h10, 8'h00);
        win(OFF_CTRL, 8'h50, 8'h00, 2);
        rchk(OFF_C0_LOW, 8'h02);
        rchk(OFF_C0_HIGH, 8'h02);
        rchk(OFF_C1_LOW, 8'h10);
        win(OFF_MODE, 8'h03, 8'h33, 2);
        rchk(OFF_C1_LOW, 8'h12);
        load(OFF_C1_LOW, 8'hFE, 8'h00);
        n0 = baud_n;
        win(OFF_MODE, 8'h23, 8'h33, 3);
        rchk(OFF_C1_LOW, 8'h01);
        rchk(OFF_CTRL, 8'h00);
        chk("baud ticks", 8'h01, 8'(baud_n - n0));
        $display("test split done");
    endtask : t_split

    // gate pin one: edge-type request flag and counter one gating
    task automatic t_ext();
        wr(OFF_IRQ_CLR, 8'h0F);
        wr(OFF_MODE, 8'h90);
        load(OFF_C1_LOW, 8'h00, 8'h00);
        wr(OFF_CTRL, 8'h04);
        u_pins.set_gate(1'b1, 1'b0);
        repeat (36) @(posedge clk);
        rchk(OFF_CTRL, 8'h0C);
        rchk(OFF_IRQ_STAT, 8'h08);
        win(OFF_CTRL, 8'h44, 8'h04, 3);
        rchk(OFF_CTRL, 8'h04);
        rchk(OFF_C1_LOW, 8'h00);
        u_pins.set_gate(1'b1, 1'b1);
        repeat (24) @(posedge clk);
        win(OFF_CTRL, 8'h44, 8'h04, 2);
        rchk(OFF_C1_LOW, 8'h02);
        wr(OFF_CTRL, 8'h00);
        $display("test ext done");
    endtask : t_ext

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_timer();
        t_modes();
        t_pins();
        t_gate();
        t_split();
        t_ext();
        final_report();
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

endmodule : tb_top
